// >>> hw/ctl_sel.v
// control selector function block, executed once per i_exec pulse
`timescale 1ns/10ps
`default_nettype none
`include "ctl_sel_regs.vh"
// Summary of operation
// - one connected input drives the output
// - two connected: choose between those two
// - three connected: choose among all three
// - high, low or middle selection type
// - manual: no selection, output held
// - manual: operator value written to output
// - bad connected input forces manual mode
// - input good again returns to automatic
// - downstream back value tracks output backward
// - back value driven to each upstream source
// - output carries value and status
module ctl_sel (
  input  wire                 i_sys_clk,
  input  wire                 i_rst,
  input  wire                 i_exec,
  input  wire                 i_target_auto,
  input  wire [1:0]           i_sel_type,
  input  wire [2:0]           i_connected,
  input  wire [`CS_VAL_W-1:0] i_sel_a,
  input  wire [`CS_ST_W-1:0]  i_sel_a_st,
  input  wire [`CS_VAL_W-1:0] i_sel_b,
  input  wire [`CS_ST_W-1:0]  i_sel_b_st,
  input  wire [`CS_VAL_W-1:0] i_sel_c,
  input  wire [`CS_ST_W-1:0]  i_sel_c_st,
  input  wire                 i_man_wr,
  input  wire [`CS_VAL_W-1:0] i_man_val,
  input  wire [`CS_VAL_W-1:0] i_back_calc_input,
  input  wire [`CS_ST_W-1:0]  i_back_calc_input_st,
  output reg  [`CS_VAL_W-1:0] o_out_val,
  output reg  [`CS_ST_W-1:0]  o_out_st,
  output reg                  o_actual_auto,
  output reg  [1:0]           o_sel_idx,
  output reg  [`CS_VAL_W-1:0] o_back_calc_to_source_a,
  output reg  [`CS_VAL_W-1:0] o_back_calc_to_source_b,
  output reg  [`CS_VAL_W-1:0] o_back_calc_to_source_c,
  output reg  [`CS_ST_W-1:0]  o_back_calc_st
);
  // -----------------------------------------------------------
  // mode states
  // -----------------------------------------------------------
  // one-hot mode codes; only the automatic one lets inputs through
  localparam [2:0] ST_AUTO   = 3'h1;                          // selecting from inputs
  localparam [2:0] ST_OPER   = 3'h2;                          // manual, asked by target mode
  localparam [2:0] ST_FORCED = 3'h4;                          // manual, forced by a bad input

  wire [1:0]           pick_idx;
  wire [1:0]           sel_idx;
  wire [2:0]           bad_vec;
  wire                 any_bad;
  wire                 run_auto;
  wire                 have_input;
  wire                 lone_input;
  wire                 take_pick;
  wire                 take_man;
  wire [`CS_VAL_W-1:0] pick_val;
  wire [`CS_ST_W-1:0]  pick_st;
  reg  [2:0]           mode_r;
  reg  [2:0]           mode_nxt;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  // bad status decode, shared by all three inputs
  function is_bad;
    input [`CS_ST_W-1:0] st;
    begin
      is_bad = (st == `CS_ST_BAD);
    end
  endfunction

  // true when exactly one input is connected
  function single_conn;
    input [2:0] conn;
    begin
      case (conn)
        3'h1, 3'h2, 3'h4: single_conn = 1'b1;
        default:          single_conn = 1'b0;
      endcase
    end
  endfunction

  // index of the lowest connected input
  function [1:0] first_conn;
    input [2:0] conn;
    begin
      if (conn[0])
        first_conn = 2'h0;
      else if (conn[1])
        first_conn = 2'h1;
      else
        first_conn = 2'h2;
    end
  endfunction

  // value of the input at an index
  function [`CS_VAL_W-1:0] val_at;
    input [1:0]           idx;
    input [`CS_VAL_W-1:0] va;
    input [`CS_VAL_W-1:0] vb;
    input [`CS_VAL_W-1:0] vc;
    begin
      case (idx)
        2'h0:    val_at = va;
        2'h1:    val_at = vb;
        default: val_at = vc;
      endcase
    end
  endfunction

  // status of the input at an index
  function [`CS_ST_W-1:0] st_at;
    input [1:0]          idx;
    input [`CS_ST_W-1:0] sa;
    input [`CS_ST_W-1:0] sb;
    input [`CS_ST_W-1:0] sc;
    begin
      case (idx)
        2'h0:    st_at = sa;
        2'h1:    st_at = sb;
        default: st_at = sc;
      endcase
    end
  endfunction

  // -----------------------------------------------------------
  // selection
  // -----------------------------------------------------------
  // high, low or middle among the connected inputs
  sel_pick u_pick (
    .i_val_a    (i_sel_a),
    .i_val_b    (i_sel_b),
    .i_val_c    (i_sel_c),
    .i_use      (i_connected),
    .i_sel_type (i_sel_type),
    .o_idx      (pick_idx)
  );

  // a lone connected input is passed straight through
  assign lone_input = single_conn(i_connected);
  assign sel_idx    = lone_input ? first_conn(i_connected) : pick_idx;
  assign pick_val   = val_at(sel_idx, i_sel_a, i_sel_b, i_sel_c);
  assign pick_st    = st_at(sel_idx, i_sel_a_st, i_sel_b_st, i_sel_c_st);

  // bad status on any connected input
  assign bad_vec    = {is_bad(i_sel_c_st), is_bad(i_sel_b_st),
                       is_bad(i_sel_a_st)} & i_connected;
  assign any_bad    = |bad_vec;
  assign run_auto   = i_target_auto & ~any_bad;
  assign have_input = |i_connected;

  // -----------------------------------------------------------
  // mode
  // -----------------------------------------------------------
  // mode is re-evaluated only in an execution slot
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_AUTO: begin
        if (i_exec && !run_auto)
          mode_nxt = i_target_auto ? ST_FORCED : ST_OPER;
      end
      ST_OPER: begin
        if (i_exec && run_auto)
          mode_nxt = ST_AUTO;
        else if (i_exec && i_target_auto)
          mode_nxt = ST_FORCED;
      end
      ST_FORCED: begin
        if (i_exec && run_auto)
          mode_nxt = ST_AUTO;
        else if (i_exec && !i_target_auto)
          mode_nxt = ST_OPER;
      end
      default: begin
        mode_nxt = ST_OPER;
      end
    endcase
  end

  // mode register and the actual mode flag
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= ST_OPER;
      o_actual_auto <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      o_actual_auto <= (mode_nxt == ST_AUTO);
    end
  end

  // -----------------------------------------------------------
  // primary output
  // -----------------------------------------------------------
  // auto takes the pick; no input connected leaves it held
  assign take_pick = i_exec & run_auto & have_input;
  // operator write only while the mode before the edge is manual
  assign take_man  = (mode_r != ST_AUTO) & i_man_wr;

  // value, status and index of the primary output
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out_val <= `CS_OUT_RST;
      o_out_st <= `CS_ST_BAD;
      o_sel_idx <= 2'h0;
    end else begin
      if (take_pick) begin
        o_out_val <= pick_val;
        o_out_st <= pick_st;
        o_sel_idx <= sel_idx;
      end
      // later assignment: a write in the same slot wins
      if (take_man) begin
        o_out_val <= i_man_val;
        o_out_st <= `CS_ST_GOOD;
      end
    end
  end

  // -----------------------------------------------------------
  // back calculation
  // -----------------------------------------------------------
  // downstream tracking value copied to every upstream source
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_back_calc_to_source_a <= `CS_OUT_RST;
      o_back_calc_to_source_b <= `CS_OUT_RST;
      o_back_calc_to_source_c <= `CS_OUT_RST;
      o_back_calc_st <= `CS_ST_BAD;
    end else if (i_exec) begin
      o_back_calc_to_source_a <= i_back_calc_input;
      o_back_calc_to_source_b <= i_back_calc_input;
      o_back_calc_to_source_c <= i_back_calc_input;
      o_back_calc_st <= i_back_calc_input_st;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ctl_sel_regs.vh
// constants for the control selector block
`ifndef CTL_SEL_REGS_VH
`define CTL_SEL_REGS_VH
`define CS_VAL_W      16
`define CS_ST_W       2
`define CS_ST_BAD     2'h0
`define CS_ST_UNCERT  2'h1
`define CS_ST_GOOD    2'h2
`define CS_SEL_HIGH   2'h0
`define CS_SEL_LOW    2'h1
`define CS_SEL_MID    2'h2
`define CS_OUT_RST    16'h0000
`endif

// >>> hw/sel_pick.v
// combinational picker: high, low or median of two or three signed values
`timescale 1ns/10ps
`default_nettype none
`include "ctl_sel_regs.vh"
module sel_pick (
  input  wire [`CS_VAL_W-1:0] i_val_a,
  input  wire [`CS_VAL_W-1:0] i_val_b,
  input  wire [`CS_VAL_W-1:0] i_val_c,
  input  wire [2:0]           i_use,
  input  wire [1:0]           i_sel_type,
  output reg  [1:0]           o_idx
);
  // signed greater-than, used for every comparison
  function gt;
    input [`CS_VAL_W-1:0] x;
    input [`CS_VAL_W-1:0] y;
    begin
      gt = $signed(x) > $signed(y);
    end
  endfunction

  reg [1:0] hi;
  reg [1:0] lo;
  reg [1:0] p;
  reg [1:0] q;
  reg [`CS_VAL_W-1:0] pv;
  reg [`CS_VAL_W-1:0] qv;

  // choose among connected inputs; with two the middle is the lower
  always @* begin
    hi = 2'h0;
    lo = 2'h0;
    p = 2'h0;
    q = 2'h1;
    pv = i_val_a;
    qv = i_val_b;
    o_idx = 2'h0;
    if (i_use == 3'h7) begin
      hi = gt(i_val_a, i_val_b) ? (gt(i_val_a, i_val_c) ? 2'h0 : 2'h2)
                                : (gt(i_val_b, i_val_c) ? 2'h1 : 2'h2);
      lo = gt(i_val_b, i_val_a) ? (gt(i_val_c, i_val_a) ? 2'h0 : 2'h2)
                                : (gt(i_val_c, i_val_b) ? 2'h1 : 2'h2);
      case (i_sel_type)
        `CS_SEL_HIGH: o_idx = hi;
        `CS_SEL_LOW:  o_idx = lo;
        default:      o_idx = 2'h3 ^ hi ^ lo ^ 2'h0 ^
                              ((hi == lo) ? 2'h3 : 2'h0);
      endcase
      if (i_sel_type == `CS_SEL_MID && hi != lo)
        o_idx = (hi != 2'h0 && lo != 2'h0) ? 2'h0 :
                (hi != 2'h1 && lo != 2'h1) ? 2'h1 : 2'h2;
      else if (i_sel_type == `CS_SEL_MID)
        o_idx = hi;
    end else begin
      if (!i_use[0]) begin
        p = 2'h1;
        pv = i_val_b;
      end
      if (i_use[0] && i_use[1]) begin
        q = 2'h1;
        qv = i_val_b;
      end else begin
        q = 2'h2;
        qv = i_val_c;
      end
      if (i_sel_type == `CS_SEL_HIGH)
        o_idx = gt(qv, pv) ? q : p;
      else
        o_idx = gt(qv, pv) ? p : q;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ctl_sel_assertions.sv
// assertion checker for the control selector
`timescale 1ns/10ps
`default_nettype none
module ctl_sel_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_exec,
  input wire logic        i_target_auto,
  input wire logic [2:0]  i_connected,
  input wire logic [15:0] i_sel_a,
  input wire logic [1:0]  i_sel_a_st,
  input wire logic        i_man_wr,
  input wire logic [15:0] i_man_val,
  input wire logic [15:0] i_back_calc_input,
  input wire logic [15:0] o_out_val,
  input wire logic [1:0]  o_out_st,
  input wire logic        o_actual_auto,
  input wire logic [15:0] o_back_calc_to_source_a
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // only source a connected and asked for auto
  wire man = !o_actual_auto;
  wire a_only = i_exec && i_target_auto && i_connected == 3'h1;
  chk_man_hold: assert property (man && i_exec && !i_man_wr |=> o_actual_auto || $stable(o_out_val))
    else $error("output moved in manual");
  chk_man_write: assert property (man && i_man_wr |=> o_out_val == $past(i_man_val) && o_out_st == 2'h2)
    else $error("manual write lost");
  chk_auto_refuse: assert property (o_actual_auto && i_man_wr && !i_exec |=> $stable(o_out_val))
    else $error("manual write taken in auto");
  chk_bad_man: assert property (i_exec && i_connected[0] && i_sel_a_st == 2'h0 |=> man)
    else $error("bad input kept auto");
  chk_good_auto: assert property (a_only && i_sel_a_st == 2'h2 |=> o_actual_auto)
    else $error("no return to auto");
  chk_only_a: assert property (a_only && i_sel_a_st == 2'h2 && o_actual_auto |=>
    o_out_val == $past(i_sel_a) && o_out_st == 2'h2)
    else $error("single input not passed");
  chk_back_copy: assert property (o_actual_auto && i_exec |=> o_back_calc_to_source_a == $past(i_back_calc_input))
    else $error("back value not copied");
  chk_out_quiet: assert property (!i_exec && !i_man_wr |=> $stable(o_out_val) && $stable(o_out_st))
    else $error("output moved without request");
  cov_man_wr: cover property (man && i_man_wr);
  cov_bad: cover property (i_exec && i_sel_a_st == 2'h0);
  cov_auto: cover property (o_actual_auto && i_exec);
  cov_return: cover property (!o_actual_auto ##1 o_actual_auto);
endmodule
bind ctl_sel ctl_sel_chk chk (.*);
`default_nettype wire

// >>> testbench/ctl_sel_far.sv
// downstream partner model for the control selector
`timescale 1ns/10ps
`default_nettype none
module ctl_sel_far (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_out_val,
  output var  logic [15:0] o_bc,
  output var  logic [1:0]  o_bc_st
);
  // tracking value follows the selector output
  always @(posedge i_sys_clk) begin
    o_bc    <= i_out_val;
    o_bc_st <= 2'h2;
  end
endmodule
`default_nettype wire

// >>> testbench/ctl_sel_tb.sv
// self-checking testbench for the control selector
`timescale 1ns/10ps
`default_nettype none
module ctl_sel_tb;
  logic clk = 1'b0, rst = 1'b1, ex = 1'b0, ta = 1'b1, mw = 1'b0, au;
  logic [1:0] ty = 2'h0, sa = 2'h2, sb = 2'h2, sc = 2'h2, os, bs, ist, si;
  logic [2:0] cn = 3'h7;
  logic [15:0] a = 16'h0005, b = 16'hFFFD, c = 16'h0009, mv = 16'h0123, ov, bi, ba, bb, bc;
  int num_errors = 0, cmp_count = 0;
  initial forever #4 clk = ~clk;
  ctl_sel DUT (.i_sys_clk(clk), .i_rst(rst), .i_exec(ex), .i_target_auto(ta), .i_sel_type(ty),
    .i_connected(cn), .i_sel_a(a), .i_sel_a_st(sa), .i_sel_b(b), .i_sel_b_st(sb), .i_sel_c(c),
    .i_sel_c_st(sc), .i_man_wr(mw), .i_man_val(mv), .i_back_calc_input(bi), .i_back_calc_input_st(ist),
    .o_out_val(ov), .o_out_st(os), .o_actual_auto(au), .o_sel_idx(si), .o_back_calc_to_source_a(ba),
    .o_back_calc_to_source_b(bb), .o_back_calc_to_source_c(bc), .o_back_calc_st(bs));
  ctl_sel_far far (.i_sys_clk(clk), .i_out_val(ov), .o_bc(bi), .o_bc_st(ist));
  task chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task run;
    @(negedge clk) ex = 1'b1;
    @(negedge clk) ex = 1'b0;
  endtask
  task wr;
    @(negedge clk) mw = 1'b1;
    @(negedge clk) mw = 1'b0;
  endtask
  task t_pick;
    run;
    for (int i = 0; i < 3; i++) begin
      ty = i[1:0];
      cn = 3'h7;
      run;
      chk("out3", ov, i == 0 ? c : i == 1 ? b : a);
      chk("idx3", {14'h0, si}, i == 0 ? 16'h0002 : i == 1 ? 16'h0001 : 16'h0000);
      cn = 3'h3;
      run;
      chk("out2", ov, i == 0 ? a : b);
    end
    ty = 2'h3;
    cn = 3'h7;
    run;
    chk("mid3", ov, a);
    ty = 2'h1;
    cn = 3'h5;
    run;
    chk("lo_ac", ov, a);
    cn = 3'h6;
    run;
    chk("lo_bc", ov, b);
    cn = 3'h4;
    run;
    chk("lone_c", ov, c);
    chk("idx_c", {14'h0, si}, 16'h0002);
    ty = 2'h0;
    cn = 3'h2;
    run;
    chk("lone_b", ov, b);
    cn = 3'h0;
    run;
    chk("none", ov, b);
    cn = 3'h1;
    run;
    run;
    chk("back", ba, a);
    chk("back_b", bb, a);
    chk("back_c", bc, a);
    chk("back_st", {14'h0, bs}, 16'h0002);
    chk("lone_a", ov, a);
    chk("idx_a", {14'h0, si}, 16'h0000);
    chk("stat", {14'h0, os}, 16'h0002);
    $display("pick test done");
  endtask
  task t_man;
    a = 16'h8000;
    sa = 2'h0;
    run;
    run;
    chk("mode", {15'h0, au}, 16'h0000);
    chk("held", ov, 16'h0005);
    wr;
    chk("man", ov, mv);
    chk("man_st", {14'h0, os}, 16'h0002);
    sa = 2'h2;
    run;
    run;
    chk("auto", {15'h0, au}, 16'h0001);
    chk("pick", ov, a);
    wr;
    chk("refuse", ov, a);
    $display("manual test done");
  endtask
  task t_target;
    cn = 3'h7;
    sc = 2'h0;
    run;
    chk("bad_c", {15'h0, au}, 16'h0000);
    chk("held_c", ov, a);
    sc = 2'h2;
    ta = 1'b0;
    run;
    chk("tmode", {15'h0, au}, 16'h0000);
    chk("thold", ov, a);
    mv = 16'h0456;
    @(negedge clk) ex = 1'b1;
    mw = 1'b1;
    @(negedge clk) ex = 1'b0;
    mw = 1'b0;
    chk("tboth", ov, mv);
    ta = 1'b1;
    run;
    chk("tauto", {15'h0, au}, 16'h0001);
    chk("tpick", ov, c);
    chk("tidx", {14'h0, si}, 16'h0002);
    $display("target test done");
  endtask
  task final_report;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_pick;
    t_man;
    t_target;
    final_report;
  end
endmodule
`default_nettype wire
